/* File: core/jbs_pkg.sv */
// Constants and types for the boundary-scan and programming test port.
// Assumes a 100 MHz system clock that oversamples the external test clock.
package jbs_pkg;
  localparam int unsigned IR_W = 4;
  localparam logic [3:0] IR_EXTEST = 4'h0;
  localparam logic [3:0] IR_SAMPLE = 4'h5;
  localparam logic [3:0] IR_IDCODE = 4'h6;
  localparam logic [3:0] IR_ISP_ERASE = 4'h8;
  localparam logic [3:0] IR_ISP_PROG = 4'h9;
  localparam logic [3:0] IR_ISP_VERIFY = 4'ha;
  localparam logic [3:0] IR_ISP_ADDR = 4'hb;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [3:0] IR_RESET = 4'h1;
  // Identification value is arbitrary
  localparam logic [31:0] IDCODE_RESET = 32'h1234_5679;
  localparam int unsigned ISP_DR_W = 16;
  localparam int unsigned CLK_MHZ = 100;
  // Fixed nonvolatile pulse intervals, in microseconds
  localparam int unsigned PULSE_US = 10;
  localparam int unsigned PULSE_CYCLES = PULSE_US * CLK_MHZ;
  typedef enum logic [15:0] {
    TLR = 16'h0001, RTI = 16'h0002, SELDR = 16'h0004, CAPDR = 16'h0008,
    SHDR = 16'h0010, EX1DR = 16'h0020, PADR = 16'h0040, EX2DR = 16'h0080,
    UPDR = 16'h0100, SELIR = 16'h0200, CAPIR = 16'h0400, SHIR = 16'h0800,
    EX1IR = 16'h1000, PAIR = 16'h2000, EX2IR = 16'h4000, UPIR = 16'h8000
  } jbs_tap_type;
endpackage : jbs_pkg

/* File: core/jbs_sync.sv */
// Two-flop synchroniser bank for the test, boundary and shared pins.
// Assumes inputs are asynchronous to the clock.
`timescale 1ns/10ps
`default_nettype none
module jbs_sync #(
  parameter int W = 4
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule : jbs_sync
`default_nettype wire

/* File: core/jbs_port.sv */
// Boundary-scan and in-system programming test port.
// Assumes test clock, mode and data pins are asynchronous; the test clock
// is sampled and its edges found on CLOCK_I.
// Functional notes
// - The port follows the standard test access port protocol.
// - With the port disabled the four test pins act as user I/O.
// - With the port enabled four pins are dedicated to the test signals.
// - Sample/preload captures pin levels and loads a pattern, pins untouched.
// - Extest drives the boundary pattern out and captures the inputs.
// - Bypass puts a single-bit register between data in and data out.
// - Idcode puts the identification register between data in and out.
// - Vendor instructions erase, program and verify the nonvolatile cells.
// - Each programming stage is a fixed pulse plus a shifting interval.
`timescale 1ns/10ps
`default_nettype none
module jbs_port
  import jbs_pkg::*;
#(
  parameter int BSR_W = 8,
  parameter int NV_WORDS = 16,
  parameter int PULSE_CYC = PULSE_CYCLES
) (
  input wire logic CLOCK_I,
  input wire logic ARST_N_I,
  input wire logic PORT_EN_I,
  input wire logic TCK_I,
  input wire logic TMS_I,
  input wire logic TDI_I,
  output logic TDO_O,
  output logic TDO_OE_O,
  input wire logic [3:0] UIO_OUT_I,
  input wire logic [3:0] UIO_OE_I,
  output logic [3:0] UIO_IN_O,
  output logic [3:0] TPIN_OUT_O,
  output logic [3:0] TPIN_OE_O,
  input wire logic [3:0] TPIN_IN_I,
  input wire logic [BSR_W-1:0] CORE_OUT_I,
  output logic [BSR_W-1:0] PIN_OUT_O,
  input wire logic [BSR_W-1:0] PIN_IN_I,
  output logic [BSR_W-1:0] CORE_IN_O,
  output logic NV_BUSY_O
);
  typedef struct packed {
    logic tck_d;
    jbs_tap_type tap;
    logic [IR_W-1:0] ir_sh;
    logic [IR_W-1:0] ir;
    logic [31:0] dr_sh;
    logic [BSR_W-1:0] bsr_upd;
    logic tdo;
    logic tdo_oe;
    logic [$clog2(NV_WORDS)-1:0] addr;
    logic [ISP_DR_W-1:0] rd_data;
    logic [31:0] pulse_cnt;
    logic [1:0] op;
  } jbs_state_type;

  jbs_state_type s_r, s_nxt;
  logic [ISP_DR_W-1:0] nv_mem [NV_WORDS];
  logic [BSR_W-1:0] pin_s;
  logic [3:0] tp_s;
  logic tck_s, tms_s, tdi_s, rise, fall, nv_we;
  logic [ISP_DR_W-1:0] nv_wdata;

  function automatic int unsigned dr_len(input logic [IR_W-1:0] ir);
    case (ir)
      IR_EXTEST, IR_SAMPLE: dr_len = BSR_W;
      IR_IDCODE: dr_len = 32;
      IR_ISP_PROG, IR_ISP_VERIFY, IR_ISP_ADDR: dr_len = ISP_DR_W;
      default: dr_len = 1;
    endcase
  endfunction : dr_len

  ////////////////////////////////////////////////////////////////////////
  jbs_sync #(.W(3)) u_sync_tap (
    .clk_i(CLOCK_I),
    .arst_n_i(ARST_N_I),
    .d_i({TCK_I, TMS_I, TDI_I}),
    .q_o({tck_s, tms_s, tdi_s})
  );
  jbs_sync #(.W(BSR_W)) u_sync_pin (
    .clk_i(CLOCK_I),
    .arst_n_i(ARST_N_I),
    .d_i(PIN_IN_I),
    .q_o(pin_s)
  );
  jbs_sync #(.W(4)) u_sync_uio (
    .clk_i(CLOCK_I),
    .arst_n_i(ARST_N_I),
    .d_i(TPIN_IN_I),
    .q_o(tp_s)
  );

  // Port disabled gates the edges so the TAP holds its current state
  assign rise = PORT_EN_I && tck_s && !s_r.tck_d;
  assign fall = PORT_EN_I && !tck_s && s_r.tck_d;

  ////////////////////////////////////////////////////////////////////////
  // Pins as user I/O when disabled, test data out when enabled
  always_comb begin
    if (PORT_EN_I) begin
      TPIN_OUT_O = {3'h0, s_r.tdo};
      TPIN_OE_O = {3'h0, s_r.tdo_oe};
      UIO_IN_O = 4'h0;
    end else begin
      TPIN_OUT_O = UIO_OUT_I;
      TPIN_OE_O = UIO_OE_I;
      UIO_IN_O = tp_s;
    end
  end
  assign TDO_O = s_r.tdo;
  assign TDO_OE_O = s_r.tdo_oe && PORT_EN_I;
  assign CORE_IN_O = pin_s;
  assign PIN_OUT_O = (s_r.ir == IR_EXTEST) ? s_r.bsr_upd : CORE_OUT_I;
  assign NV_BUSY_O = (s_r.pulse_cnt != 32'h0);

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    int unsigned len;
    len = 1;
    s_nxt = s_r;
    nv_we = 1'b0;
    nv_wdata = s_r.dr_sh[ISP_DR_W-1:0];
    s_nxt.tck_d = tck_s;
    len = dr_len(s_r.ir);
    if (s_r.pulse_cnt != 32'h0) begin
      s_nxt.pulse_cnt = s_r.pulse_cnt - 32'h1;
      if (s_r.pulse_cnt == 32'h1) begin
        if (s_r.op == 2'h1) begin
          nv_we = 1'b1;
        end
        if (s_r.op == 2'h2) begin
          s_nxt.rd_data = nv_mem[s_r.addr];
        end
      end
    end
    if (rise) begin
      case (s_r.tap)
        TLR: s_nxt.tap = tms_s ? TLR : RTI;
        RTI: s_nxt.tap = tms_s ? SELDR : RTI;
        SELDR: s_nxt.tap = tms_s ? SELIR : CAPDR;
        CAPDR: s_nxt.tap = tms_s ? EX1DR : SHDR;
        SHDR: s_nxt.tap = tms_s ? EX1DR : SHDR;
        EX1DR: s_nxt.tap = tms_s ? UPDR : PADR;
        PADR: s_nxt.tap = tms_s ? EX2DR : PADR;
        EX2DR: s_nxt.tap = tms_s ? UPDR : SHDR;
        UPDR: s_nxt.tap = tms_s ? SELDR : RTI;
        SELIR: s_nxt.tap = tms_s ? TLR : CAPIR;
        CAPIR: s_nxt.tap = tms_s ? EX1IR : SHIR;
        SHIR: s_nxt.tap = tms_s ? EX1IR : SHIR;
        EX1IR: s_nxt.tap = tms_s ? UPIR : PAIR;
        PAIR: s_nxt.tap = tms_s ? EX2IR : PAIR;
        EX2IR: s_nxt.tap = tms_s ? UPIR : SHIR;
        UPIR: s_nxt.tap = tms_s ? SELDR : RTI;
        default: s_nxt.tap = TLR;
      endcase
      case (s_r.tap)
        TLR: s_nxt.ir = IR_IDCODE;
        CAPIR: s_nxt.ir_sh = IR_RESET;
        SHIR: s_nxt.ir_sh = {tdi_s, s_r.ir_sh[IR_W-1:1]};
        UPIR: s_nxt.ir = s_r.ir_sh;
        CAPDR: begin
          case (s_r.ir)
            IR_EXTEST, IR_SAMPLE: s_nxt.dr_sh = 32'(pin_s);
            IR_IDCODE: s_nxt.dr_sh = IDCODE_RESET;
            IR_ISP_VERIFY: s_nxt.dr_sh = 32'(s_r.rd_data);
            default: s_nxt.dr_sh = 32'h0;
          endcase
        end
        SHDR: begin
          s_nxt.dr_sh = s_r.dr_sh >> 1;
          s_nxt.dr_sh[len-1] = tdi_s;
        end
        UPDR: begin
          case (s_r.ir)
            IR_EXTEST, IR_SAMPLE: s_nxt.bsr_upd = s_r.dr_sh[BSR_W-1:0];
            IR_ISP_ADDR: s_nxt.addr = s_r.dr_sh[$clog2(NV_WORDS)-1:0];
            IR_ISP_PROG: begin
              s_nxt.op = 2'h1;
              s_nxt.pulse_cnt = 32'(PULSE_CYC);
            end
            IR_ISP_VERIFY: begin
              s_nxt.op = 2'h2;
              s_nxt.pulse_cnt = 32'(PULSE_CYC);
            end
            IR_ISP_ERASE: begin
              s_nxt.op = 2'h3;
              s_nxt.pulse_cnt = 32'(PULSE_CYC);
            end
            default: s_nxt.op = s_r.op;
          endcase
        end
        default: s_nxt.ir = s_r.ir;
      endcase
    end
    if (fall) begin
      s_nxt.tdo_oe = (s_r.tap == SHDR) || (s_r.tap == SHIR);
      s_nxt.tdo = (s_r.tap == SHIR) ? s_r.ir_sh[0] : s_r.dr_sh[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Erase wipes all words at pulse end; memory has no reset by intent
  always_ff @(posedge CLOCK_I) begin
    if (nv_we) begin
      nv_mem[s_r.addr] <= nv_wdata;
    end else if (s_r.op == 2'h3 && s_r.pulse_cnt == 32'h1) begin
      for (int i = 0; i < NV_WORDS; i++) begin
        nv_mem[i] <= '1;
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      s_r <= '{tck_d: 1'b0, tap: TLR, ir: IR_IDCODE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : jbs_port
`default_nettype wire

/* File: tb/jbs_port_asserts.sv */
// Checker for the test port: pin sharing, data-out edge, pulse length.
// Bound into every port instance; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module jbs_port_asserts
  import jbs_pkg::*;
#(
  parameter int PULSE_CYC = 4
) (
  input wire logic CLOCK_I,
  input wire logic ARST_N_I,
  input wire logic PORT_EN_I,
  input wire logic TCK_I,
  input wire logic TDO_O,
  input wire logic TDO_OE_O,
  input wire logic [3:0] UIO_OUT_I,
  input wire logic [3:0] UIO_OE_I,
  input wire logic [3:0] UIO_IN_O,
  input wire logic [3:0] TPIN_OUT_O,
  input wire logic [3:0] TPIN_OE_O,
  input wire logic [3:0] TPIN_IN_I,
  input wire logic NV_BUSY_O
);
  logic [15:0] busy_cnt;
  default clocking dc @(posedge CLOCK_I);
  endclocking
  default disable iff (!ARST_N_I);
  //////////////////////////////////////////////////////////////////////
  // Run length of busy; pulse judged by count, one cycle of slack
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) busy_cnt <= 16'h0;
    else busy_cnt <= NV_BUSY_O ? busy_cnt + 16'h1 : 16'h0;
  end
  user_drive_a: assert property (
    (!PORT_EN_I && $stable({PORT_EN_I, UIO_OUT_I, UIO_OE_I}))[*4] |->
    TPIN_OE_O == UIO_OE_I && TPIN_OUT_O == UIO_OUT_I) else $error("user drive lost");
  user_in_a: assert property (
    (!PORT_EN_I && $stable({PORT_EN_I, TPIN_IN_I}))[*4] |-> UIO_IN_O == TPIN_IN_I)
    else $error("user input lost");
  pins_taken_a: assert property (
    PORT_EN_I[*5] |-> TPIN_OE_O[3:1] == 3'h0 && UIO_IN_O == 4'h0) else $error("pins not taken");
  tdo_route_a: assert property (
    PORT_EN_I[*5] |-> TPIN_OUT_O[0] == TDO_O && TPIN_OE_O[0] == TDO_OE_O)
    else $error("data out not on pin");
  tdo_fall_a: assert property (
    $changed(TDO_O) |-> !$past(TCK_I) && !$past(TCK_I, 2)) else $error("data out off fall");
  tdo_hold_a: assert property (
    TCK_I && $past(TCK_I) && $past(TCK_I, 2) |-> $stable(TDO_O)) else $error("data out moved");
  pulse_len_a: assert property (
    $fell(NV_BUSY_O) |-> busy_cnt + 1 >= PULSE_CYC && busy_cnt <= PULSE_CYC + 1)
    else $error("pulse length wrong");
  pulse_max_a: assert property (
    NV_BUSY_O |-> busy_cnt <= PULSE_CYC) else $error("pulse too long");
endmodule : jbs_port_asserts
bind jbs_port jbs_port_asserts #(.PULSE_CYC(PULSE_CYC)) jbs_port_asserts_inst (
  .CLOCK_I(CLOCK_I), .ARST_N_I(ARST_N_I), .PORT_EN_I(PORT_EN_I), .TCK_I(TCK_I),
  .TDO_O(TDO_O), .TDO_OE_O(TDO_OE_O), .UIO_OUT_I(UIO_OUT_I), .UIO_OE_I(UIO_OE_I),
  .UIO_IN_O(UIO_IN_O), .TPIN_OUT_O(TPIN_OUT_O), .TPIN_OE_O(TPIN_OE_O),
  .TPIN_IN_I(TPIN_IN_I), .NV_BUSY_O(NV_BUSY_O)
);
`default_nettype wire

/* File: tb/jbs_ctrl.sv */
// Controller model: test clock, mode and data toward the port.
// Assumes the bench clock; the bench calls its tasks.
`timescale 1ns/10ps
`default_nettype none
module jbs_ctrl (
  input wire logic clk_i,
  input wire logic tdo_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o
);
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////
  // Bit of 16 clocks; test clock idles low between bits
  task automatic step(input logic m, input logic v, output logic q);
    @(posedge clk_i);
    tms_o <= m;
    tdi_o <= v;
    repeat (7) @(posedge clk_i);
    q = tdo_i;
    tck_o <= 1'b1;
    repeat (8) @(posedge clk_i);
    tck_o <= 1'b0;
  endtask : step
  // Scan from idle, LSB first, back to idle
  task automatic go(input logic ir, input int n, input logic [31:0] din,
                    output logic [31:0] dout);
    logic q;
    dout = 32'h0;
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], dout[i]);
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask : go
endmodule : jbs_ctrl
`default_nettype wire

/* File: tb/jbs_port_test.sv */
// Bench for the test port: scans, boundary cells, programming, pins.
// The controller model makes the test clock at 160 ns.
`timescale 1ns/10ps
`default_nettype none
module jbs_port_test;
  import jbs_pkg::*;
  localparam int PULSE_SIM = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic en = 1'b1;
  logic bq = 1'b0;
  logic tck, tms, tdi, tdo, toe, busy;
  logic [3:0] uo = 4'h6, ue = 4'ha, ui, po, pe;
  logic [7:0] co = 8'h3c, bi = 8'h96, bo, ci;
  logic [31:0] d;
  int n_errors = 0, samples_checked = 0, pulses = 0;
  // Undriven pin 0 pulled up
  wire [3:0] pi = (pe & po) | (~pe & {tdi, tms, tck, 1'b1});
  jbs_port #(.PULSE_CYC(PULSE_SIM)) jbs_port_inst (
    .CLOCK_I(clk), .ARST_N_I(rst_n), .PORT_EN_I(en), .TCK_I(tck), .TMS_I(tms),
    .TDI_I(tdi), .TDO_O(tdo), .TDO_OE_O(toe), .UIO_OUT_I(uo), .UIO_OE_I(ue),
    .UIO_IN_O(ui), .TPIN_OUT_O(po), .TPIN_OE_O(pe), .TPIN_IN_I(pi), .CORE_OUT_I(co),
    .PIN_OUT_O(bo), .PIN_IN_I(bi), .CORE_IN_O(ci), .NV_BUSY_O(busy)
  );
  jbs_ctrl jbs_ctrl_inst (.clk_i(clk), .tdo_i(pi[0]), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    bq <= busy;
    if (busy && !bq) pulses <= pulses + 1;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic check(input string s, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s: expected %h, seen %h", s, exp, seen);
    end
  endtask : check
  task automatic give_verdict;
    if (n_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  task automatic ins(input logic [3:0] op, input int n, input logic [31:0] din);
    jbs_ctrl_inst.go(1'b1, IR_W, {28'h0, op}, d);
    jbs_ctrl_inst.go(1'b0, n, din, d);
    if (op == IR_ISP_ERASE || op == IR_ISP_PROG || op == IR_ISP_VERIFY) begin
      repeat (PULSE_SIM) @(posedge clk);
      check("pulse over", busy, 32'h0);
    end
  endtask : ins
  task automatic t_scan;
    logic q;
    jbs_ctrl_inst.go(1'b0, 32, 32'h0, d);
    check("idcode", d, IDCODE_RESET);
    jbs_ctrl_inst.go(1'b1, IR_W, {28'h0, IR_BYPASS}, d);
    check("ir capture", d, 32'h1);
    jbs_ctrl_inst.go(1'b0, 8, 32'ha5, d);
    check("bypass", d, 32'h4a);
    jbs_ctrl_inst.go(1'b1, IR_W, {28'h0, IR_IDCODE}, d);
    jbs_ctrl_inst.step(1'b1, 1'b0, q);
    repeat (2) jbs_ctrl_inst.step(1'b0, 1'b0, q);
    for (int i = 0; i < 32; i++) begin
      jbs_ctrl_inst.step(i == 15 || i == 31, 1'b0, d[i]);
      if (i == 3) check("shift out", {toe, tdo}, {1'b1, IDCODE_RESET[3]});
      if (i == 15) begin
        jbs_ctrl_inst.step(1'b0, 1'b0, q);
        jbs_ctrl_inst.step(1'b1, 1'b0, q);
        check("pause oe", toe, 32'h0);
        jbs_ctrl_inst.step(1'b0, 1'b0, q);
      end
    end
    jbs_ctrl_inst.step(1'b1, 1'b0, q);
    jbs_ctrl_inst.step(1'b0, 1'b0, q);
    check("paused idcode", d, IDCODE_RESET);
  endtask : t_scan
  task automatic t_bsr;
    ins(IR_SAMPLE, 8, 32'h5a);
    check("sample", d, 32'h96);
    check("core side", {bo, ci}, 32'h3c96);
    bi <= 8'h69;
    ins(IR_EXTEST, 8, 32'ha5);
    check("extest in", d, 32'h69);
    check("extest out", bo, 32'ha5);
  endtask : t_bsr
  task automatic t_isp;
    ins(IR_ISP_ADDR, 16, 32'h3);
    ins(IR_ISP_ERASE, 16, 32'h0);
    ins(IR_ISP_VERIFY, 16, 32'h0);
    ins(IR_ISP_VERIFY, 16, 32'h0);
    check("erased", d, 32'hffff);
    ins(IR_ISP_PROG, 16, 32'hc3a5);
    ins(IR_ISP_VERIFY, 16, 32'h0);
    ins(IR_ISP_VERIFY, 16, 32'h0);
    check("programmed", d, 32'hc3a5);
    check("pulses", pulses, 32'h6);
  endtask : t_isp
  task automatic t_pins;
    @(posedge clk);
    en <= 1'b0;
    repeat (8) @(posedge clk);
    check("user drive", {pe, po}, 32'ha6);
    check("user in", ui, {1'b0, tms, 2'h3});
    en <= 1'b1;
    repeat (8) @(posedge clk);
    check("test pins", {pe[3:1], ui}, 32'h0);
  endtask : t_pins
  task automatic t_reset;
    logic q;
    jbs_ctrl_inst.go(1'b1, IR_W, {28'h0, IR_BYPASS}, d);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    check("reset outputs", {toe, tdo, busy}, 32'h0);
    rst_n <= 1'b1;
    jbs_ctrl_inst.step(1'b0, 1'b0, q);
    jbs_ctrl_inst.go(1'b0, 32, 32'h0, d);
    check("reset idcode", d, IDCODE_RESET);
  endtask : t_reset
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) jbs_ctrl_inst.step(1'b1, 1'b0, d[0]);
    jbs_ctrl_inst.step(1'b0, 1'b0, d[0]);
    t_scan;
    t_bsr;
    t_isp;
    t_pins;
    t_reset;
    give_verdict;
  end
  // Some 430 bits of 16 clocks; over three times that as margin
  initial begin
    #250000;
    n_errors++;
    give_verdict;
  end
endmodule : jbs_port_test
`default_nettype wire
